// *** fpm_consts.svh ***
// constants for the flat panel mapping and power control register bank
// assumes inclusion by fpm_power_regs.sv and the self-checking bench, not by fpm_pkg.sv
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH
// register indices on the host index/data port
`define FPM_IDX_UNLOCK 8'h35
`define FPM_IDX_ADDR 8'h38
`define FPM_IDX_DATA 8'h39
`define FPM_IDX_PWR 8'h3A
`define FPM_IDX_HEIGHT 8'h3B
`define FPM_IDX_BLINK 8'h3C
`define FPM_IDX_COLOR 8'h3E
`define FPM_IDX_REFRESH 8'h3F
// unlock pattern for mapping registers, bits 6:4 = 011
`define FPM_UNLOCK_MASK 8'h70
`define FPM_UNLOCK_VAL 8'h30
// power control field positions
`define FPM_PWR_SYS_SEL 7
`define FPM_PWR_DIV_SEL 6
`define FPM_PWR_HOST_REL 5
`define FPM_PWR_GRAY64 3
`define FPM_PWR_CBR 2
`define FPM_PWR_WEIGHT 1
// power control bits visible only while unlocked, and bits readable at all (7:6 never read)
`define FPM_PWR_LOCKED_RD 8'hFC
`define FPM_PWR_HIDDEN_RD 8'h3F
`define FPM_PWR_RESET 8'h11
// powerdown refresh register layout
`define FPM_REF_GEN_EN 7
`define FPM_REF_ADD 11'h005
// blink and color panel field positions
`define FPM_BLK_SCLK_RISE 6
`define FPM_BLK_PULSE_VBLANK 7
`define FPM_CLR_BORDER_PULSE 7
`define FPM_CLR_WHITE 6
`define FPM_CLR_COLOR_LCD 5
`define FPM_CLR_REV_TEXT 3
// blink code limits
`define FPM_BLINK_MAX_CODE 3'h5
// internal clock divider ratio minus one
`define FPM_DIV8_LAST 3'h7
`endif

// *** fpm_pkg.sv ***
// types shared by the flat panel mapping and power control bank
// assumes fpm_consts.svh alongside
`default_nettype none
package fpm_pkg;
    // power modes, gray coded along run -> idle -> sleep and run -> gen
    typedef enum logic [2:0] {
        FPM_RUN = 3'h0,
        FPM_IDLE = 3'h1,
        FPM_SLEEP = 3'h3,
        FPM_GEN_EXT = 3'h2,
        FPM_GEN_INT = 3'h6
    } fpm_mode_t;
endpackage
`default_nettype wire

// *** fpm_power_regs.sv ***
// flat panel mapping ram, power-down and panel option register bank
// assumes one host index/data port with one-cycle read and write strobes
`include "fpm_consts.svh"
`default_nettype none
module fpm_power_regs #(
    parameter int MAP_DEPTH = 256,
    parameter int REF_W = 11
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // host index/data port
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_index_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic io_rdata_valid_out,
    output logic io_rdata_oe_out,
    output logic sys_bus_oe_out,
    // power-down and system status inputs
    input wire logic pwrdn_active_in,
    input wire logic host_release_input_in,
    input wire logic standby_refresh_input_in,
    input wire logic crt_mode_in,
    input wire logic frame_start_in,
    input wire logic panel_reverse_en_in,
    input wire logic text_mode_in,
    // power and clock control
    output fpm_pkg::fpm_mode_t power_mode_out,
    output logic clk_stop_out,
    output logic clk_div8_en_out,
    output logic refresh_tick_out,
    output logic cbr_refresh_out,
    output logic mem_access_en_out,
    output logic io_access_en_out,
    output logic dac_off_out,
    output logic panel_off_out,
    // panel options
    output logic gray64_out,
    output logic weighting_en_out,
    output logic [7:0] panel_height_out,
    output logic cursor_blink_on_out,
    output logic char_blink_on_out,
    output logic shift_clk_rising_out,
    output logic line_pulse_vblank_out,
    output logic shift_clk_vblank_off_out,
    output logic border_line_pulse_en_out,
    output logic border_white_out,
    output logic color_lcd_out,
    output logic invert_panel_data_out
);
    import fpm_pkg::*;

    logic [7:0] unlock_q;
    logic [7:0] addr_ctr_q;
    logic [7:0] pwr_q;
    logic [7:0] height_q;
    logic [7:0] blink_q;
    logic [7:0] color_q;
    logic [7:0] refcfg_q;
    logic [7:0] map_mem_q [MAP_DEPTH];
    fpm_mode_t mode_q;
    fpm_mode_t mode_d;
    logic [2:0] div_q;
    logic [REF_W-1:0] ref_cnt_q;
    logic [REF_W-1:0] ref_period;
    logic sby_q;
    logic unlocked;
    logic released;
    logic io_ok;
    logic io_wr;
    logic io_rd;
    logic map_hit;
    logic [7:0] rd_val;

    // lock decode, host release and access gating
    assign unlocked = (unlock_q & `FPM_UNLOCK_MASK) == `FPM_UNLOCK_VAL;
    assign released = pwr_q[`FPM_PWR_HOST_REL] & ~host_release_input_in;
    assign io_ok = ~released & (mode_q != FPM_SLEEP);
    assign io_wr = io_wr_in & io_ok;
    assign io_rd = io_rd_in & io_ok;
    assign map_hit = unlocked & (io_index_in == `FPM_IDX_DATA);
    assign ref_period = (REF_W'(refcfg_q[6:0]) + `FPM_REF_ADD) << 3;

    // mode decode from the general enable and the two select bits
    always_comb begin
        mode_d = FPM_RUN;
        if (pwrdn_active_in) begin
            if (!refcfg_q[`FPM_REF_GEN_EN]) begin
                mode_d = pwr_q[`FPM_PWR_SYS_SEL] ? FPM_SLEEP : FPM_IDLE;
            end else begin
                mode_d = pwr_q[`FPM_PWR_DIV_SEL] ? FPM_GEN_INT : FPM_GEN_EXT;
            end
        end
    end

    // read data mux; hidden and locked bits read as zero
    always_comb begin
        rd_val = 8'h00;
        if (io_index_in == `FPM_IDX_UNLOCK) begin
            rd_val = unlock_q;
        end else if (io_index_in == `FPM_IDX_ADDR) begin
            rd_val = unlocked ? addr_ctr_q : 8'h00;
        end else if (io_index_in == `FPM_IDX_DATA) begin
            rd_val = unlocked ? map_mem_q[addr_ctr_q] : 8'h00;
        end else if (io_index_in == `FPM_IDX_PWR) begin
            rd_val = pwr_q & `FPM_PWR_HIDDEN_RD;
            if (!unlocked) begin
                rd_val = rd_val & ~`FPM_PWR_LOCKED_RD;
            end
        end else if (io_index_in == `FPM_IDX_HEIGHT) begin
            rd_val = height_q;
        end else if (io_index_in == `FPM_IDX_BLINK) begin
            rd_val = blink_q;
        end else if (io_index_in == `FPM_IDX_COLOR) begin
            rd_val = color_q;
        end else if (io_index_in == `FPM_IDX_REFRESH) begin
            rd_val = refcfg_q;
        end
    end

    // register writes; power control only while unlocked
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            unlock_q <= 8'h00;
            pwr_q <= `FPM_PWR_RESET;
            height_q <= 8'h00;
            blink_q <= 8'h00;
            color_q <= 8'h00;
            refcfg_q <= 8'h00;
        end else if (io_wr) begin
            if (io_index_in == `FPM_IDX_UNLOCK) begin
                unlock_q <= io_wdata_in;
            end else if (io_index_in == `FPM_IDX_PWR && unlocked) begin
                pwr_q <= io_wdata_in;
            end else if (io_index_in == `FPM_IDX_HEIGHT) begin
                height_q <= io_wdata_in;
            end else if (io_index_in == `FPM_IDX_BLINK) begin
                blink_q <= io_wdata_in;
            end else if (io_index_in == `FPM_IDX_COLOR) begin
                color_q <= io_wdata_in;
            end else if (io_index_in == `FPM_IDX_REFRESH) begin
                refcfg_q <= io_wdata_in;
            end
        end
    end

    // address counter: direct load, or step after each data access
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_ctr_q <= 8'h00;
        end else if (io_wr && unlocked && io_index_in == `FPM_IDX_ADDR) begin
            addr_ctr_q <= io_wdata_in;
        end else if ((io_wr || io_rd) && map_hit) begin
            addr_ctr_q <= addr_ctr_q + 8'h01;
        end
    end

    // mapping storage, written at the current counter entry
    always_ff @(posedge sys_clk_in) begin
        if (io_wr && map_hit) begin
            map_mem_q[addr_ctr_q] <= io_wdata_in;
        end
    end

    // read answer one cycle after the strobe, for any index; other indices read as zero
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_rdata_out <= 8'h00;
            io_rdata_valid_out <= 1'b0;
            io_rdata_oe_out <= 1'b0;
            sys_bus_oe_out <= 1'b0;
        end else begin
            io_rdata_out <= io_rd ? rd_val : 8'h00;
            io_rdata_valid_out <= io_rd;
            io_rdata_oe_out <= io_rd;
            sys_bus_oe_out <= ~released;
        end
    end

    // power mode register and derived clock and access controls
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= FPM_RUN;
            clk_stop_out <= 1'b0;
            mem_access_en_out <= 1'b1;
            io_access_en_out <= 1'b1;
            dac_off_out <= 1'b0;
            panel_off_out <= 1'b0;
            cbr_refresh_out <= 1'b0;
        end else begin
            mode_q <= mode_d;
            clk_stop_out <= mode_d == FPM_SLEEP;
            mem_access_en_out <= ~released & (mode_d != FPM_SLEEP) & (mode_d != FPM_IDLE);
            io_access_en_out <= ~released & (mode_d != FPM_SLEEP);
            dac_off_out <= mode_d != FPM_RUN;
            panel_off_out <= mode_d != FPM_RUN;
            // standby refresh is always column-before-row
            cbr_refresh_out <= pwr_q[`FPM_PWR_CBR] | (mode_d == FPM_SLEEP) | (mode_d == FPM_IDLE);
        end
    end
    assign power_mode_out = mode_q;

    // divide-by-8 clock enable for idle and internal general modes
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 3'h0;
            clk_div8_en_out <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            clk_div8_en_out <= ((mode_d == FPM_IDLE) || (mode_d == FPM_GEN_INT))
                               && div_q == `FPM_DIV8_LAST;
        end
    end

    // refresh source: standby input edge, or field period counter
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sby_q <= 1'b0;
            ref_cnt_q <= '0;
            refresh_tick_out <= 1'b0;
        end else begin
            sby_q <= standby_refresh_input_in;
            refresh_tick_out <= 1'b0;
            if (mode_q == FPM_SLEEP || mode_q == FPM_IDLE) begin
                ref_cnt_q <= '0;
                refresh_tick_out <= standby_refresh_input_in & ~sby_q;
            end else if (mode_q == FPM_GEN_EXT || (mode_q == FPM_GEN_INT && clk_div8_en_out)) begin
                if (ref_cnt_q >= ref_period - REF_W'(1)) begin
                    ref_cnt_q <= '0;
                    refresh_tick_out <= 1'b1;
                end else begin
                    ref_cnt_q <= ref_cnt_q + REF_W'(1);
                end
            end else if (mode_q == FPM_RUN) begin
                ref_cnt_q <= '0;
            end
        end
    end

    // blink generators for cursor (bits 2:0) and character (bits 5:3)
    // each generator owns its phase flop; the net gathers them without a shared variable
    wire logic [1:0] blink_on;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_blink
            logic [7:0] frm_q;
            logic on_q;
            logic [2:0] code;
            assign code = blink_q[g*3 +: 3];
            assign blink_on[g] = on_q;
            always_ff @(posedge sys_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    frm_q <= 8'h00;
                    on_q <= 1'b1;
                end else if (crt_mode_in || code == 3'h0 || code > `FPM_BLINK_MAX_CODE) begin
                    frm_q <= 8'h00;
                    on_q <= 1'b1;
                end else if (frame_start_in) begin
                    if (frm_q >= (8'h08 << (code - 3'h1)) - 8'h01) begin
                        frm_q <= 8'h00;
                        on_q <= ~on_q;
                    end else begin
                        frm_q <= frm_q + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // panel option outputs
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gray64_out <= 1'b0;
            weighting_en_out <= 1'b0;
            panel_height_out <= 8'h00;
            cursor_blink_on_out <= 1'b1;
            char_blink_on_out <= 1'b1;
            shift_clk_rising_out <= 1'b0;
            line_pulse_vblank_out <= 1'b0;
            shift_clk_vblank_off_out <= 1'b0;
            border_line_pulse_en_out <= 1'b0;
            border_white_out <= 1'b0;
            color_lcd_out <= 1'b0;
            invert_panel_data_out <= 1'b0;
        end else begin
            gray64_out <= pwr_q[`FPM_PWR_GRAY64];
            weighting_en_out <= pwr_q[`FPM_PWR_WEIGHT];
            panel_height_out <= height_q;
            cursor_blink_on_out <= blink_on[0];
            char_blink_on_out <= blink_on[1];
            shift_clk_rising_out <= ~crt_mode_in & blink_q[`FPM_BLK_SCLK_RISE];
            line_pulse_vblank_out <= ~crt_mode_in & blink_q[`FPM_BLK_PULSE_VBLANK];
            shift_clk_vblank_off_out <= ~crt_mode_in & blink_q[`FPM_BLK_PULSE_VBLANK];
            border_line_pulse_en_out <= color_q[`FPM_CLR_BORDER_PULSE];
            border_white_out <= color_q[`FPM_CLR_WHITE];
            color_lcd_out <= color_q[`FPM_CLR_COLOR_LCD];
            invert_panel_data_out <= panel_reverse_en_in
                                     & (~color_q[`FPM_CLR_REV_TEXT] | text_mode_in);
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_data_access;
        (io_wr_in || io_rd_in) && io_ok && map_hit;
    endsequence

    a_lock_blocks_pwr: assert property (io_wr_in && io_index_in == `FPM_IDX_PWR && !unlocked
        |=> $stable(pwr_q)) else $error("power control written while locked");
    a_counter_step: assert property (s_data_access
        |=> addr_ctr_q == $past(addr_ctr_q) + 8'h01) else $error("address counter did not step");
    a_read_entry: assert property (io_rd_in && io_ok && map_hit
        |=> io_rdata_valid_out && io_rdata_out == map_mem_q[$past(addr_ctr_q)])
        else $error("read returned wrong entry");
    a_sleep_refuse: assert property (mode_d == FPM_SLEEP
        |=> clk_stop_out && !mem_access_en_out && !io_access_en_out) else $error("sleep not refusing");
    a_idle_io_only: assert property (mode_d == FPM_IDLE && !released
        |=> !mem_access_en_out && io_access_en_out && !clk_stop_out) else $error("idle access wrong");
    a_gen_ext_direct: assert property (mode_q == FPM_GEN_EXT && mode_d == FPM_GEN_EXT
        |=> !clk_div8_en_out) else $error("external general mode divided");
    a_gen_int_div: assert property (mode_d == FPM_GEN_INT && div_q == `FPM_DIV8_LAST
        |=> clk_div8_en_out ##1 !clk_div8_en_out [*7]) else $error("internal divide not by 8");
    a_sys_bit_hidden: assert property (io_rd_in && io_ok && io_index_in == `FPM_IDX_PWR
        |=> !io_rdata_out[7] && !io_rdata_out[6]) else $error("hidden power bits read");
    a_release_tristate: assert property (released ##1 released
        |-> !sys_bus_oe_out && !io_rdata_valid_out) else $error("bus driven while released");
    a_pd_panel_off: assert property (mode_q != FPM_RUN |-> dac_off_out && panel_off_out)
        else $error("outputs on in powerdown");
    a_locked_read: assert property (io_rd_in && io_ok && io_index_in == `FPM_IDX_PWR && !unlocked
        |=> io_rdata_out[7:2] == 6'h00) else $error("locked power bits read");

    // cycles since the last refresh tick in external general mode, for the period check;
    // the first gap after entry or after a period rewrite is not judged
    logic [REF_W-1:0] gap_q;
    logic gap_armed_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_q <= '0;
            gap_armed_q <= 1'b0;
        end else if (mode_q != FPM_GEN_EXT || (io_wr && io_index_in == `FPM_IDX_REFRESH)) begin
            gap_q <= '0;
            gap_armed_q <= 1'b0;
        end else if (refresh_tick_out) begin
            gap_q <= REF_W'(1);
            gap_armed_q <= 1'b1;
        end else begin
            gap_q <= gap_q + REF_W'(1);
        end
    end
    a_refresh_period: assert property (mode_q == FPM_GEN_EXT && refresh_tick_out && gap_armed_q
        |-> gap_q == ((REF_W'(refcfg_q[6:0]) + `FPM_REF_ADD) << 3))
        else $error("refresh period wrong");
endmodule
`default_nettype wire

// *** fpm_host_model.sv ***
// host cpu model: one-cycle register strobes on the index/data port
// assumes the bank samples strobes on rising edges and answers a read within 3 cycles
`default_nettype none
module fpm_host_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] io_rdata_in,
    input wire logic io_rdata_valid_in,
    output logic io_wr_out,
    output logic io_rd_out,
    output logic [7:0] io_index_out,
    output logic [7:0] io_wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle port at time zero
    initial begin
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_index_out = 8'h00;
        io_wdata_out = 8'h00;
    end
    // write: held over one rising edge, then released lines stop showing the old value
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] dat);
        @(negedge sys_clk_in);
        io_index_out = idx;
        io_wdata_out = dat;
        io_wr_out = 1'b1;
        @(negedge sys_clk_in);
        io_wr_out = 1'b0;
        io_index_out = ~idx;
        io_wdata_out = ~dat;
    endtask
    // read: strobe over one rising edge, then wait a bounded time for the answer
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] dat, output logic got);
        @(negedge sys_clk_in);
        io_index_out = idx;
        io_rd_out = 1'b1;
        @(negedge sys_clk_in);
        io_rd_out = 1'b0;
        io_index_out = ~idx;
        got = 1'b0;
        dat = 8'h00;
        for (int i = 0; i < 3; i++) begin
            if (!got && io_rdata_valid_in === 1'b1) begin
                got = 1'b1;
                dat = io_rdata_in;
            end
            if (!got) @(negedge sys_clk_in);
        end
    endtask
endmodule
`default_nettype wire

// *** flat_panel_power_mapping_regs_tb.sv ***
// self-checking bench for the mapping, power-down and panel option bank
// assumes fpm_host_model drives the register port; inputs change on falling edges
`include "fpm_consts.svh"
`default_nettype none
module flat_panel_power_mapping_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpm_pkg::*;
    logic sys_clk_in, rst_in, io_wr, io_rd, valid, got, pwrdn, hrel, sref, crt, frame, rev, text;
    logic [7:0] idx, wdat, rdat, rv, hgt;
    logic stop, div8, tick, cbr, mem_en, io_en, dac_off, pnl_off, g64, wt, cur, chr;
    logic srise, lpvb, soff, blp, white, color, inv, bus_oe, oe;
    fpm_mode_t mode;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    fpm_host_model u_host (.sys_clk_in(sys_clk_in), .io_rdata_in(rdat), .io_rdata_valid_in(valid),
        .io_wr_out(io_wr), .io_rd_out(io_rd), .io_index_out(idx), .io_wdata_out(wdat));
    fpm_power_regs #(.MAP_DEPTH(256), .REF_W(11)) u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .io_wr_in(io_wr), .io_rd_in(io_rd), .io_index_in(idx), .io_wdata_in(wdat), .io_rdata_out(rdat),
        .io_rdata_valid_out(valid), .io_rdata_oe_out(oe), .sys_bus_oe_out(bus_oe),
        .pwrdn_active_in(pwrdn), .host_release_input_in(hrel), .standby_refresh_input_in(sref),
        .crt_mode_in(crt), .frame_start_in(frame), .panel_reverse_en_in(rev), .text_mode_in(text),
        .power_mode_out(mode), .clk_stop_out(stop), .clk_div8_en_out(div8), .refresh_tick_out(tick),
        .cbr_refresh_out(cbr), .mem_access_en_out(mem_en), .io_access_en_out(io_en),
        .dac_off_out(dac_off), .panel_off_out(pnl_off), .gray64_out(g64), .weighting_en_out(wt),
        .panel_height_out(hgt), .cursor_blink_on_out(cur), .char_blink_on_out(chr),
        .shift_clk_rising_out(srise), .line_pulse_vblank_out(lpvb), .shift_clk_vblank_off_out(soff),
        .border_line_pulse_en_out(blp), .border_white_out(white), .color_lcd_out(color),
        .invert_panel_data_out(inv));
    // 250 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    // hang guard
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chkb(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        u_host.wr_reg(i, d);
    endtask
    task automatic rd(input logic [7:0] i);
        u_host.rd_reg(i, rv, got);
    endtask
    task automatic settle();
        repeat (3) @(negedge sys_clk_in);
    endtask
    // reset view of the power register, locked and unlocked
    task automatic t_lock();
        rd(`FPM_IDX_PWR);
        chk(rv, 8'h01);
        rd(`FPM_IDX_ADDR);
        chk(rv, 8'h00);
        wr(`FPM_IDX_UNLOCK, 8'h30);
        rd(`FPM_IDX_PWR);
        chk(rv, 8'h11);
    endtask
    // data port walks the counter, wraps at the top, and locks again
    task automatic t_map();
        wr(`FPM_IDX_UNLOCK, 8'hB5);
        wr(`FPM_IDX_ADDR, 8'h05);
        wr(`FPM_IDX_DATA, 8'hAA);
        wr(`FPM_IDX_DATA, 8'hBB);
        wr(`FPM_IDX_ADDR, 8'h05);
        rd(`FPM_IDX_DATA);
        chk(rv, 8'hAA);
        rd(`FPM_IDX_DATA);
        chk(rv, 8'hBB);
        rd(`FPM_IDX_ADDR);
        chk(rv, 8'h07);
        wr(`FPM_IDX_ADDR, 8'hFF);
        wr(`FPM_IDX_DATA, 8'h5A);
        rd(`FPM_IDX_ADDR);
        chk(rv, 8'h00);
        wr(`FPM_IDX_UNLOCK, 8'h70);
        wr(`FPM_IDX_DATA, 8'hC3);
        rd(`FPM_IDX_DATA);
        chk(rv, 8'h00);
        wr(`FPM_IDX_UNLOCK, 8'h30);
        rd(`FPM_IDX_ADDR);
        chk(rv, 8'h00);
    endtask
    // option bits, hidden mode selects, and locked writes
    task automatic t_pwr();
        wr(`FPM_IDX_PWR, 8'hDF);
        settle();
        chk({5'h00, g64, cbr, wt}, 8'h07);
        rd(`FPM_IDX_PWR);
        chk(rv, 8'h1F);
        wr(`FPM_IDX_PWR, 8'h11);
        settle();
        chk({5'h00, g64, cbr, wt}, 8'h00);
        wr(`FPM_IDX_UNLOCK, 8'h00);
        wr(`FPM_IDX_PWR, 8'h1F);
        settle();
        chkb(g64, 1'b0);
        rd(`FPM_IDX_PWR);
        chk(rv, 8'h01);
        wr(`FPM_IDX_UNLOCK, 8'h30);
    endtask
    // the four power-down modes from the enable and select bits
    task automatic t_modes();
        logic [7:0] pv [4] = '{8'h91, 8'h11, 8'h91, 8'h51};
        logic [7:0] ex [4] = '{{2'b00, FPM_SLEEP, 3'b001}, {2'b00, FPM_IDLE, 3'b010},
            {2'b00, FPM_GEN_EXT, 3'b110}, {2'b00, FPM_GEN_INT, 3'b110}};
        int n;
        for (int k = 0; k < 4; k++) begin
            wr(`FPM_IDX_REFRESH, {k[1], 7'h00});
            wr(`FPM_IDX_PWR, pv[k]);
            pwrdn = 1'b1;
            settle();
            chk({2'b00, mode, mem_en, io_en, stop}, ex[k]);
            chkb(dac_off & pnl_off, 1'b1);
            rd(`FPM_IDX_HEIGHT);
            chkb(got, ex[k][1]);
            n = 0;
            if (k < 2) begin
                sref = 1'b1;
                repeat (6) begin
                    @(negedge sys_clk_in);
                    n += int'(tick);
                end
                sref = 1'b0;
                chk(8'(n), 8'h01);
            end
            if (k[0]) begin
                n = 0;
                repeat (32) begin
                    @(negedge sys_clk_in);
                    n += int'(div8);
                end
                chk(8'(n), 8'h04);
            end
            if (k == 2) begin
                n = 0;
                for (int j = 0; j < 100 && tick !== 1'b1; j++) @(negedge sys_clk_in);
                do begin
                    @(negedge sys_clk_in);
                    n++;
                end while (tick !== 1'b1 && n < 100);
                chk(8'(n), 8'h28);
            end
            pwrdn = 1'b0;
            settle();
            chk({5'h00, mode}, {5'h00, FPM_RUN});
        end
    endtask
    // host release tristates the bus and ignores cycles
    task automatic t_release();
        wr(`FPM_IDX_PWR, 8'h31);
        hrel = 1'b0;
        settle();
        chkb(bus_oe, 1'b0);
        rd(`FPM_IDX_PWR);
        chkb(got, 1'b0);
        wr(`FPM_IDX_PWR, 8'h11);
        hrel = 1'b1;
        settle();
        chkb(bus_oe, 1'b1);
        rd(`FPM_IDX_PWR);
        chk(rv, 8'h31);
        chkb(oe, 1'b1);
        wr(`FPM_IDX_PWR, 8'h11);
    endtask
    task automatic frame_step();
        @(negedge sys_clk_in);
        frame = 1'b1;
        @(negedge sys_clk_in);
        frame = 1'b0;
        @(negedge sys_clk_in);
    endtask
    // frames between two toggles of the chosen blink output
    task automatic blink_period(input logic sel, input logic [7:0] exp);
        logic last;
        int hits;
        int per;
        hits = 0;
        per = 0;
        last = sel ? chr : cur;
        for (int k = 0; k < 600 && hits < 2; k++) begin
            frame_step();
            per++;
            if ((sel ? chr : cur) !== last) begin
                last = ~last;
                hits++;
                if (hits == 2) chk(8'(per), exp);
                per = 0;
            end
        end
        chkb(hits == 2, 1'b1);
    endtask
    // steady blink outputs over twenty frames
    task automatic steady();
        logic ok;
        ok = 1'b1;
        repeat (20) begin
            frame_step();
            if ((cur & chr) !== 1'b1) ok = 1'b0;
        end
        chkb(ok, 1'b1);
    endtask
    task automatic t_blink();
        for (int n = 1; n < 6; n++) begin
            wr(`FPM_IDX_BLINK, {2'b11, 3'(n), 3'(n)});
            settle();
            chk({5'h00, srise, lpvb, soff}, 8'h07);
            blink_period(1'b0, 8'(8 << (n - 1)));
            blink_period(1'b1, 8'(8 << (n - 1)));
        end
        crt = 1'b1;
        steady();
        chk({5'h00, srise, lpvb, soff}, 8'h00);
        crt = 1'b0;
        wr(`FPM_IDX_BLINK, 8'h00);
        steady();
        chk({5'h00, srise, lpvb, soff}, 8'h00);
        wr(`FPM_IDX_BLINK, 8'h36);
        steady();
    endtask
    // panel height, color panel options and reverse video
    task automatic t_panel();
        wr(`FPM_IDX_HEIGHT, 8'hEF);
        rd(`FPM_IDX_HEIGHT);
        chk(rv, 8'hEF);
        chk(hgt, 8'hEF);
        wr(`FPM_IDX_COLOR, 8'hE8);
        rev = 1'b1;
        settle();
        chk({4'h0, blp, white, color, inv}, 8'h0E);
        text = 1'b1;
        settle();
        chkb(inv, 1'b1);
        wr(`FPM_IDX_COLOR, 8'h00);
        text = 1'b0;
        settle();
        chk({4'h0, blp, white, color, inv}, 8'h01);
        rev = 1'b0;
        settle();
        chkb(inv, 1'b0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst_in = 1'b1;
        {pwrdn, hrel, sref, crt, frame, rev, text} = 7'b0100000;
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_in = 1'b0;
        t_lock();
        t_map();
        t_pwr();
        t_modes();
        t_release();
        t_blink();
        t_panel();
        wrap_up();
    end
endmodule
`default_nettype wire
